/* design/bdc_pkg.sv */
// Purpose: shared constants, encodings and helpers for the bridge data path slice
// Assumes: one clock domain; controller commands arrive on the same clock
// Notes: host and memory command codes are local choices; pci codes follow the bus map
package bdc_pkg;

	// ------------------------------------------------------------
	// widths and depths
	// ------------------------------------------------------------
	localparam int unsigned DATA_W = 64;
	localparam int unsigned DWORD_W = 32;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned MPAR_W = DATA_W / BYTE_W;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned PF_DEPTH = 4;
	localparam int unsigned PF_PTR_W = 2;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned PCI_PAR_W = 2;
	localparam int unsigned PCI_PAR_SEG = DWORD_W / PCI_PAR_W;

	// ------------------------------------------------------------
	// host command group codes
	// ------------------------------------------------------------
	localparam logic [4:0] HOST_NOP = 5'h00;
	localparam logic [4:0] HOST_CPU_MEM_READ_DRIVE = 5'h01;
	localparam logic [4:0] HOST_PF_FIRST = 5'h02;
	localparam logic [4:0] HOST_PF_TOGGLE_A = 5'h03;
	localparam logic [4:0] HOST_PF_TOGGLE_B = 5'h04;
	localparam logic [4:0] HOST_ADDR_DRIVE = 5'h05;

	// ------------------------------------------------------------
	// memory command group codes
	// ------------------------------------------------------------
	localparam logic [2:0] MEM_NOP = 3'h0;
	localparam logic [2:0] MEM_RD_FILL_FIRST = 3'h1;
	localparam logic [2:0] MEM_RD_FILL_NEXT = 3'h2;
	localparam logic [2:0] MEM_RETIRE_CPU_WR = 3'h3;
	localparam logic [2:0] MEM_RETIRE_PCI_WR = 3'h4;
	localparam logic [2:0] MEM_RETIRE_PCI_SHIFTED = 3'h5;
	localparam logic [2:0] MEM_DRIVE_HOLD = 3'h6;

	// ------------------------------------------------------------
	// pci command group codes (inbound parity ones)
	// ------------------------------------------------------------
	localparam logic [3:0] PCI_PF_LATCH_FIRST = 4'h0;
	localparam logic [3:0] PCI_PF_LATCH_TOGGLE_A = 4'h1;
	localparam logic [3:0] PCI_PF_LATCH_TOGGLE_B = 4'h2;
	localparam logic [3:0] PCI_LATCH_MASTER_ADDR = 4'h3;
	localparam logic [3:0] PCI_POST_WR_ADDR = 4'h8;
	localparam logic [3:0] PCI_POST_WR_DATA = 4'h9;

	localparam logic [PF_PTR_W-1:0] PF_PTR_FIRST = 2'h0;
	localparam logic [PF_PTR_W-1:0] PF_PTR_STEP = 2'h1;

	// ------------------------------------------------------------
	// state encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {H_IDLE = 3'h1, H_ARM = 3'h2, H_DRIVE = 3'h4} bdc_host_st_t;
	typedef enum logic [1:0] {M_IDLE = 2'h1, M_DRIVE = 2'h2} bdc_mem_st_t;
	typedef enum logic [3:0] {TOG_NONE = 4'h1, TOG_FIRST = 4'h2, TOG_A = 4'h4, TOG_B = 4'h8} bdc_tog_t;

	// next prefetch pointer from previous and current toggle command
	function automatic logic [PF_PTR_W-1:0] pf_next_ptr(bdc_tog_t last, bdc_tog_t cmd,
		logic [PF_PTR_W-1:0] ptr);
		logic [PF_PTR_W-1:0] r;
		r = ptr;
		if (cmd == TOG_FIRST) begin
			r = PF_PTR_FIRST;
		end else if (cmd == TOG_A && (last == TOG_FIRST || last == TOG_B)) begin
			r = ptr + PF_PTR_STEP;
		end else if (cmd == TOG_B && last == TOG_A) begin
			r = ptr + PF_PTR_STEP;
		end
		return r;
	endfunction

	// pci parity, one bit per half dword
	function automatic logic [PCI_PAR_W-1:0] pci_par(logic [DWORD_W-1:0] d);
		logic [PCI_PAR_W-1:0] p;
		for (int i = 0; i < PCI_PAR_W; i++) begin
			p[i] = ^d[i*PCI_PAR_SEG +: PCI_PAR_SEG];
		end
		return p;
	endfunction

endpackage

/* design/bdc_fifo.sv */
// Purpose: write data queue ahead of the memory retire path
// Assumes: single clock, clock enable freezes all state
// Notes: full and empty are registered flags
`timescale 1ns/1ns
module bdc_fifo #(
	parameter int unsigned WIDTH = 64,
	parameter int unsigned DEPTH = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// fill side
	input wire logic [WIDTH-1:0] i_in_data,
	input wire logic i_in_valid,
	output logic o_in_ready,
	// drain side
	output logic [WIDTH-1:0] o_out_data,
	output logic o_out_valid,
	input wire logic i_out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] PTR_ONE = AW'(1);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic full;
		logic empty;
	} bdc_fifo_st_t;

	bdc_fifo_st_t s_ff;
	bdc_fifo_st_t nxt_s;
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// handshake and next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		push = i_in_valid && !s_ff.full;
		pop = i_out_ready && !s_ff.empty;
		if (push) begin
			nxt_s.mem[s_ff.wp] = i_in_data;
			nxt_s.wp = (s_ff.wp == PTR_LAST) ? '0 : s_ff.wp + PTR_ONE;
		end
		if (pop) begin
			nxt_s.rp = (s_ff.rp == PTR_LAST) ? '0 : s_ff.rp + PTR_ONE;
		end
		if (push && !pop) begin
			nxt_s.cnt = s_ff.cnt + CNT_ONE;
		end else if (pop && !push) begin
			nxt_s.cnt = s_ff.cnt - CNT_ONE;
		end
		nxt_s.full = (nxt_s.cnt == CNT_FULL);
		nxt_s.empty = (nxt_s.cnt == '0);
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			s_ff <= '0;
			s_ff.empty <= 1'b1;
		end else if (i_ce) begin
			s_ff <= nxt_s;
		end
	end

	assign o_in_ready = !s_ff.full;
	assign o_out_valid = !s_ff.empty;
	assign o_out_data = s_ff.mem[s_ff.rp];

endmodule

/* design/bdc_datapath.sv */
// Purpose: command driven data path slice between host, memory and pci buses
// Assumes: controller drives command groups synchronously on i_clk (20 MHz)
// Notes: pci enable release is combinational so the lines drop in the same cycle
//
// Notes on behaviour
// - host drive sampled: data bus driven after two cycles, address after one.
// - host nop sampled: host bus released after a single cycle.
// - memory read drive puts register data on host bus before memory data valid.
// - memory data/parity reach host through register; latch enable samples, else holds.
// - memory-sourced host data released only on nop together with memory latch enable.
// - memory fill commands capture memory data bus at end of that cycle.
// - retire starts memory bus drive; hold command keeps it; memory nop releases.
// - pci drive enable sampled; asserted in cycle N drives lines from N+1.
// - negating pci drive enable releases lines in the same cycle.
// - parity one clock after data inbound, same cycle as data outbound.
// - prefetch latch commands time parity like latch commands, inbound one clock later.
// - first-fill command latches pci lines into first location every cycle.
// - alternating toggles advance write pointer; repeated toggle overwrites same location.
// - host prefetch commands use the same toggle scheme for the read pointer.
// - host first-read drives host data two clocks after sampling.
// - host data follows current content of the prefetch location.
// - sub-dword reads re-drive the same dword without advancing, up to four times.
// - pci codes: first fill 0000b, toggle A 0001b, toggle B 0010b, inbound parity.
`timescale 1ns/1ns
module bdc_datapath #(
	parameter int unsigned DATA_W = bdc_pkg::DATA_W,
	parameter int unsigned ADDR_W = bdc_pkg::ADDR_W,
	parameter int unsigned FIFO_DEPTH = bdc_pkg::FIFO_DEPTH
) (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// controller command groups
	input wire logic [4:0] i_host_cmd_group,
	input wire logic [2:0] i_mem_cmd_group,
	input wire logic [3:0] i_pci_cmd_group,
	input wire logic i_mem_data_latch_en,
	input wire logic i_pci_bus_drive_en,
	// host bus
	input wire logic [ADDR_W-1:0] i_host_addr_src,
	output logic [ADDR_W-1:0] o_host_addr,
	output logic o_host_addr_oe,
	output logic [DATA_W-1:0] o_host_data_bus,
	output logic [bdc_pkg::MPAR_W-1:0] o_host_parity,
	output logic o_host_data_oe,
	// memory bus
	input wire logic [DATA_W-1:0] i_mem_data_bus,
	input wire logic [bdc_pkg::MPAR_W-1:0] i_mem_parity,
	output logic [DATA_W-1:0] o_mem_data_bus,
	output logic o_mem_data_oe,
	output logic [DATA_W-1:0] o_mem_fill_data,
	output logic o_mem_fill_valid,
	// write data queue fill side
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	// pci bus
	input wire logic [bdc_pkg::DWORD_W-1:0] i_pci_ad,
	input wire logic [bdc_pkg::DWORD_W-1:0] i_pci_tx_data,
	output logic [bdc_pkg::DWORD_W-1:0] o_pci_ad,
	output logic o_pci_ad_oe,
	output logic [bdc_pkg::PCI_PAR_W-1:0] o_pci_parity_out
);
	localparam int unsigned DW = bdc_pkg::DWORD_W;
	localparam int unsigned PW = bdc_pkg::PF_PTR_W;
	localparam int unsigned BW = bdc_pkg::BYTE_W;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		bdc_pkg::bdc_host_st_t hst;
		logic src_mem;
		logic [DATA_W-1:0] host_data;
		logic [bdc_pkg::MPAR_W-1:0] host_par;
		logic host_data_oe;
		logic [ADDR_W-1:0] host_addr;
		logic host_addr_oe;
		logic [DATA_W-1:0] mem_reg;
		logic [bdc_pkg::MPAR_W-1:0] mem_par_reg;
		bdc_pkg::bdc_mem_st_t mst;
		logic [DATA_W-1:0] mem_out;
		logic mem_oe;
		logic [DATA_W-1:0] fill_data;
		logic fill_valid;
		logic [bdc_pkg::PF_DEPTH-1:0][DW-1:0] pf;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		bdc_pkg::bdc_tog_t last_wr;
		bdc_pkg::bdc_tog_t last_rd;
		logic drv_pci;
		logic [DW-1:0] pci_ad;
		logic [bdc_pkg::PCI_PAR_W-1:0] pci_par;
	} bdc_dp_st_t;

	bdc_dp_st_t s_ff;
	bdc_dp_st_t nxt_s;

	// decoded commands
	logic host_nop;
	logic host_data_drive;
	logic host_release;
	logic mem_retire;
	logic mem_fill;
	logic pci_inbound;
	bdc_pkg::bdc_tog_t host_tog;
	bdc_pkg::bdc_tog_t pci_tog;

	// write queue drain side
	logic [DATA_W-1:0] q_data;
	logic q_valid;
	logic q_pop;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	always_comb begin
		host_nop = (i_host_cmd_group == bdc_pkg::HOST_NOP);
		host_data_drive = (i_host_cmd_group == bdc_pkg::HOST_CPU_MEM_READ_DRIVE) ||
			(i_host_cmd_group == bdc_pkg::HOST_PF_FIRST) ||
			(i_host_cmd_group == bdc_pkg::HOST_PF_TOGGLE_A) ||
			(i_host_cmd_group == bdc_pkg::HOST_PF_TOGGLE_B);
		// memory-sourced data waits for the latch enable before release
		host_release = host_nop && (!s_ff.src_mem || i_mem_data_latch_en);
		mem_retire = (i_mem_cmd_group == bdc_pkg::MEM_RETIRE_CPU_WR) ||
			(i_mem_cmd_group == bdc_pkg::MEM_RETIRE_PCI_WR) ||
			(i_mem_cmd_group == bdc_pkg::MEM_RETIRE_PCI_SHIFTED);
		mem_fill = (i_mem_cmd_group == bdc_pkg::MEM_RD_FILL_FIRST) ||
			(i_mem_cmd_group == bdc_pkg::MEM_RD_FILL_NEXT);
		// parity source: inbound for latch type commands
		pci_inbound = (i_pci_cmd_group == bdc_pkg::PCI_PF_LATCH_FIRST) ||
			(i_pci_cmd_group == bdc_pkg::PCI_PF_LATCH_TOGGLE_A) ||
			(i_pci_cmd_group == bdc_pkg::PCI_PF_LATCH_TOGGLE_B) ||
			(i_pci_cmd_group == bdc_pkg::PCI_LATCH_MASTER_ADDR) ||
			(i_pci_cmd_group == bdc_pkg::PCI_POST_WR_ADDR) ||
			(i_pci_cmd_group == bdc_pkg::PCI_POST_WR_DATA);
		unique case (i_host_cmd_group)
			bdc_pkg::HOST_PF_FIRST: host_tog = bdc_pkg::TOG_FIRST;
			bdc_pkg::HOST_PF_TOGGLE_A: host_tog = bdc_pkg::TOG_A;
			bdc_pkg::HOST_PF_TOGGLE_B: host_tog = bdc_pkg::TOG_B;
			default: host_tog = bdc_pkg::TOG_NONE;
		endcase
		unique case (i_pci_cmd_group)
			bdc_pkg::PCI_PF_LATCH_FIRST: pci_tog = bdc_pkg::TOG_FIRST;
			bdc_pkg::PCI_PF_LATCH_TOGGLE_A: pci_tog = bdc_pkg::TOG_A;
			bdc_pkg::PCI_PF_LATCH_TOGGLE_B: pci_tog = bdc_pkg::TOG_B;
			default: pci_tog = bdc_pkg::TOG_NONE;
		endcase
		q_pop = i_ce && mem_retire;
	end

	// ------------------------------------------------------------
	// write data queue
	// ------------------------------------------------------------
	bdc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_queue (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.i_in_data(i_wr_data),
		.i_in_valid(i_wr_valid),
		.o_in_ready(o_wr_ready),
		.o_out_data(q_data),
		.o_out_valid(q_valid),
		.i_out_ready(q_pop)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;

		// host data drive sequencer, two cycles to drive, one to release
		unique case (s_ff.hst)
			bdc_pkg::H_IDLE: begin
				if (host_data_drive) begin
					nxt_s.hst = bdc_pkg::H_ARM;
					nxt_s.src_mem = (i_host_cmd_group == bdc_pkg::HOST_CPU_MEM_READ_DRIVE);
				end
			end
			bdc_pkg::H_ARM: begin
				if (host_nop) begin
					nxt_s.hst = bdc_pkg::H_IDLE;
				end else begin
					nxt_s.hst = bdc_pkg::H_DRIVE;
				end
			end
			bdc_pkg::H_DRIVE: begin
				if (host_release) begin
					nxt_s.hst = bdc_pkg::H_IDLE;
				end else if (host_data_drive) begin
					nxt_s.src_mem = (i_host_cmd_group == bdc_pkg::HOST_CPU_MEM_READ_DRIVE);
				end
			end
		endcase
		nxt_s.host_data_oe = (nxt_s.hst == bdc_pkg::H_DRIVE);

		// host address drives one cycle after its command
		if (i_host_cmd_group == bdc_pkg::HOST_ADDR_DRIVE) begin
			nxt_s.host_addr_oe = 1'b1;
			nxt_s.host_addr = i_host_addr_src;
		end else if (host_nop) begin
			nxt_s.host_addr_oe = 1'b0;
		end

		// memory to host register, latch enable acts as clock enable
		if (i_mem_data_latch_en) begin
			nxt_s.mem_reg = i_mem_data_bus;
			nxt_s.mem_par_reg = i_mem_parity;
		end

		// host data source: memory register or current prefetch dword
		if (s_ff.src_mem) begin
			nxt_s.host_data = s_ff.mem_reg;
			nxt_s.host_par = s_ff.mem_par_reg;
		end else begin
			nxt_s.host_data = {(DATA_W / DW){s_ff.pf[s_ff.rd_ptr]}};
			for (int i = 0; i < bdc_pkg::MPAR_W; i++) begin
				nxt_s.host_par[i] = ^nxt_s.host_data[i*BW +: BW];
			end
		end

		// host read pointer follows the toggle scheme
		if (host_tog != bdc_pkg::TOG_NONE) begin
			nxt_s.rd_ptr = bdc_pkg::pf_next_ptr(s_ff.last_rd, host_tog, s_ff.rd_ptr);
			nxt_s.last_rd = host_tog;
		end

		// memory fill capture at the end of the command cycle
		nxt_s.fill_valid = mem_fill;
		if (mem_fill) begin
			nxt_s.fill_data = i_mem_data_bus;
		end

		// memory bus drive: retire starts, hold keeps, nop releases
		if (mem_retire) begin
			nxt_s.mst = bdc_pkg::M_DRIVE;
			if (i_mem_cmd_group == bdc_pkg::MEM_RETIRE_PCI_SHIFTED) begin
				nxt_s.mem_out = {q_data[DATA_W-DW-1:0], q_data[DATA_W-1:DATA_W-DW]};
			end else begin
				nxt_s.mem_out = q_data;
			end
		end else if (i_mem_cmd_group == bdc_pkg::MEM_NOP) begin
			nxt_s.mst = bdc_pkg::M_IDLE;
		end
		nxt_s.mem_oe = (nxt_s.mst == bdc_pkg::M_DRIVE);

		// pci drive enable sampled on the clock
		nxt_s.drv_pci = i_pci_bus_drive_en;
		nxt_s.pci_ad = i_pci_tx_data;
		if (pci_inbound) begin
			nxt_s.pci_par = bdc_pkg::pci_par(i_pci_ad);
		end else begin
			nxt_s.pci_par = bdc_pkg::pci_par(i_pci_tx_data);
		end

		// prefetch fill from pci lines, toggled write pointer
		if (pci_tog != bdc_pkg::TOG_NONE) begin
			nxt_s.wr_ptr = bdc_pkg::pf_next_ptr(s_ff.last_wr, pci_tog, s_ff.wr_ptr);
			nxt_s.last_wr = pci_tog;
			nxt_s.pf[nxt_s.wr_ptr] = i_pci_ad;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			s_ff <= '0;
			s_ff.hst <= bdc_pkg::H_IDLE;
			s_ff.mst <= bdc_pkg::M_IDLE;
			s_ff.last_wr <= bdc_pkg::TOG_FIRST;
			s_ff.last_rd <= bdc_pkg::TOG_FIRST;
		end else if (i_ce) begin
			s_ff <= nxt_s;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_host_addr = s_ff.host_addr;
	assign o_host_addr_oe = s_ff.host_addr_oe;
	assign o_host_data_bus = s_ff.host_data;
	assign o_host_parity = s_ff.host_par;
	assign o_host_data_oe = s_ff.host_data_oe;
	assign o_mem_data_bus = s_ff.mem_out;
	assign o_mem_data_oe = s_ff.mem_oe;
	assign o_mem_fill_data = s_ff.fill_data;
	assign o_mem_fill_valid = s_ff.fill_valid;
	assign o_pci_ad = s_ff.pci_ad;
	// release without waiting for a clock edge
	assign o_pci_ad_oe = s_ff.drv_pci && i_pci_bus_drive_en;
	assign o_pci_parity_out = s_ff.pci_par;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_host_data_delay: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && s_ff.hst == bdc_pkg::H_IDLE && host_data_drive) |=>
		(!o_host_data_oe and ((i_ce && !host_nop) |=> o_host_data_oe)))
		else $error("host data drive not two cycles after command");

	chk_host_addr_delay: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && i_host_cmd_group == bdc_pkg::HOST_ADDR_DRIVE) |=>
		(o_host_addr_oe && o_host_addr == $past(i_host_addr_src)))
		else $error("host address not driven one cycle after command");

	chk_host_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && o_host_data_oe && host_nop && (!s_ff.src_mem || i_mem_data_latch_en)) |=>
		!o_host_data_oe)
		else $error("host data not released after nop");

	chk_host_hold_mem_data_latch_en: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && o_host_data_oe && s_ff.src_mem && !i_mem_data_latch_en) |=> o_host_data_oe)
		else $error("host data released without latch enable");

	chk_mem_reg_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && i_mem_data_latch_en) ##1 (i_ce && !i_mem_data_latch_en) |=>
		(s_ff.mem_reg == $past(i_mem_data_bus, 2)))
		else $error("memory register did not sample then hold");

	chk_mem_fill_cap: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && mem_fill) |=> (o_mem_fill_valid && o_mem_fill_data == $past(i_mem_data_bus)))
		else $error("memory fill data not captured");

	chk_mem_drive_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && mem_retire) ##1 (i_ce && i_mem_cmd_group == bdc_pkg::MEM_DRIVE_HOLD) |=>
		o_mem_data_oe[*1] ##0 $stable(o_mem_data_bus))
		else $error("memory bus not held after retire");

	chk_mem_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && i_mem_cmd_group == bdc_pkg::MEM_NOP) |=> !o_mem_data_oe)
		else $error("memory bus not released on nop");

	chk_pci_drive_start: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && !i_pci_bus_drive_en) ##1 (i_ce && i_pci_bus_drive_en) |->
		!o_pci_ad_oe ##1 (!i_pci_bus_drive_en || o_pci_ad_oe))
		else $error("pci lines not driven the cycle after enable");

	chk_pci_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!i_pci_bus_drive_en |-> !o_pci_ad_oe)
		else $error("pci lines driven while enable negated");

	chk_pci_par_in: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && pci_inbound) |=> (o_pci_parity_out == bdc_pkg::pci_par($past(i_pci_ad))))
		else $error("inbound parity not one clock after data");

	chk_pf_toggle_adv: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && pci_tog == bdc_pkg::TOG_B && s_ff.last_wr == bdc_pkg::TOG_A) |=>
		(s_ff.wr_ptr == $past(s_ff.wr_ptr) + bdc_pkg::PF_PTR_STEP &&
		s_ff.pf[s_ff.wr_ptr] == $past(i_pci_ad)))
		else $error("toggle did not advance prefetch write pointer");

	chk_pf_read_same: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_ce && host_tog != bdc_pkg::TOG_NONE && host_tog == s_ff.last_rd &&
		host_tog != bdc_pkg::TOG_FIRST) |=> $stable(s_ff.rd_ptr))
		else $error("repeated host prefetch command moved read pointer");

endmodule

/* bench/bdc_pf_ctrl.sv */
// Purpose: controller model filling the prefetch buffer from pci
// Assumes: target ready comes from the bench
// Notes: ad moves every cycle so unqualified data never matches
`timescale 1ns/1ns
module bdc_pf_ctrl (
	// clock and handshake
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_trdy,
	// pci side
	output logic [3:0] o_cmd,
	output logic [31:0] o_ad,
	output logic o_busy
);
	int n = 0;
	initial begin
		o_cmd = bdc_pkg::PCI_POST_WR_ADDR;
		o_ad = 32'h0000_1234;
		o_busy = 0;
	end
	// first fill until ready, then alternate toggles
	always @(posedge i_clk) begin
		o_ad <= {o_ad[30:0], o_ad[31] ^ o_ad[21]} ^ 32'h0101_0101;
		if (!o_busy && i_go) begin
			o_busy <= 1;
			n <= 0;
			o_cmd <= bdc_pkg::PCI_PF_LATCH_FIRST;
		end else if (o_busy && i_trdy) begin
			n <= n + 1;
			o_cmd <= o_cmd == bdc_pkg::PCI_PF_LATCH_TOGGLE_A ? bdc_pkg::PCI_PF_LATCH_TOGGLE_B :
				bdc_pkg::PCI_PF_LATCH_TOGGLE_A;
			if (n == 3) begin
				o_busy <= 0;
				o_cmd <= bdc_pkg::PCI_POST_WR_ADDR;
			end
		end
	end
endmodule

/* bench/testbench.sv */
// Purpose: self-checking bench for the bridge data path slice
// Assumes: one 20 MHz clock, model fills the prefetch buffer
// Notes: random data from a fixed seed
`timescale 1ns/1ns
module testbench;
	logic clk = 0, rst_n = 0, ce = 1, le = 0, pe = 0, wv = 0, trdy = 0, go = 0, own = 1, pf_busy;
	logic hoe, aoe, moe, fv, wr, poe;
	logic [4:0] hc = 0;
	logic [2:0] mc = 0;
	logic [3:0] pc = 4'h8, pf_cmd;
	logic [1:0] ppo;
	logic [7:0] mp = 0, hpar;
	logic [31:0] ha = 0, pt = 0, pad, hadr, pout, a, d;
	logic [63:0] md = 0, wd = 0, hd, mout, fill, x, w[17];
	logic [31:0] exp_d[$];
	int seed = 96808, errors = 0, checked = 0;
	bdc_datapath i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_host_cmd_group(hc),
		.i_mem_cmd_group(mc), .i_pci_cmd_group(own ? pc : pf_cmd), .i_mem_data_latch_en(le),
		.i_pci_bus_drive_en(pe), .i_host_addr_src(ha), .o_host_addr(hadr), .o_host_addr_oe(aoe),
		.o_host_data_bus(hd), .o_host_parity(hpar), .o_host_data_oe(hoe), .i_mem_data_bus(md),
		.i_mem_parity(mp), .o_mem_data_bus(mout), .o_mem_data_oe(moe), .o_mem_fill_data(fill),
		.o_mem_fill_valid(fv), .i_wr_data(wd), .i_wr_valid(wv), .o_wr_ready(wr), .i_pci_ad(pad),
		.i_pci_tx_data(pt), .o_pci_ad(pout), .o_pci_ad_oe(poe), .o_pci_parity_out(ppo));
	bdc_pf_ctrl i_pf (.i_clk(clk), .i_go(go), .i_trdy(trdy), .o_cmd(pf_cmd), .o_ad(pad), .o_busy(pf_busy));
	always #25 clk = ~clk;
	// random target ready, record of qualified dwords
	always @(posedge clk) begin
		if (pf_busy && trdy) exp_d.push_back(pad);
		trdy <= ($random(seed) & 3) == 0;
	end
	function automatic logic [7:0] bpar(logic [63:0] v);
		for (int i = 0; i < 8; i++) bpar[i] = ^v[8*i +: 8];
	endfunction
	function automatic logic [1:0] ppar(logic [31:0] v);
		return {^v[31:16], ^v[15:0]};
	endfunction
	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// wait edges, then let updates settle
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog, far past the expected few hundred cycles
	initial begin
		#150000;
		errors++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		// prefetch fill, inbound parity one clock late
		@(posedge clk);
		go <= 1;
		own <= 0;
		@(posedge clk);
		go <= 0;
		for (int t = 0; t < 300 && (t < 2 || pf_busy); t++) begin
			@(posedge clk);
			a = pad;
			#1;
			if (t > 0) chk("pci_par_in", ppo, ppar(a));
		end
		chk("fill_count", exp_d.size(), 4);
		// host reads, each toggle held four times
		@(posedge clk);
		hc <= bdc_pkg::HOST_PF_FIRST;
		step(1);
		chk("host_oe_early", hoe, 0);
		step(1);
		chk("host_oe", hoe, 1);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			if (k > 0) hc <= k[0] ? bdc_pkg::HOST_PF_TOGGLE_A : bdc_pkg::HOST_PF_TOGGLE_B;
			d = exp_d[k];
			for (int r = 0; r < 4; r++) begin
				step(1);
				if (r > 0) chk("host_pf_data", hd, {d, d});
			end
			chk("host_pf_par", hpar, bpar({d, d}));
		end
		@(posedge clk);
		hc <= bdc_pkg::HOST_NOP;
		step(1);
		chk("host_release", hoe, 0);
		$display("test prefetch done");
		// memory read through the latch enabled register
		x = {$random(seed), $random(seed)};
		@(posedge clk);
		hc <= bdc_pkg::HOST_CPU_MEM_READ_DRIVE;
		md <= x;
		mp <= ~bpar(x);
		le <= 1;
		@(posedge clk);
		le <= 0;
		md <= ~x;
		step(1);
		chk("mem_rd_oe", hoe, 1);
		chk("mem_rd_par", hpar, 8'(~bpar(x)));
		@(posedge clk);
		hc <= bdc_pkg::HOST_NOP;
		step(1);
		chk("mem_rd_hold", hd, x);
		@(posedge clk);
		le <= 1;
		#1 chk("nop_no_latch", hoe, 1);
		@(posedge clk);
		le <= 0;
		hc <= bdc_pkg::HOST_ADDR_DRIVE;
		ha <= $random(seed);
		#1 chk("nop_latch", hoe, 0);
		step(1);
		chk("addr_oe", aoe, 1);
		chk("addr_val", hadr, ha);
		@(posedge clk);
		hc <= bdc_pkg::HOST_NOP;
		#1 chk("addr_no_data", hoe, 0);
		step(1);
		chk("addr_release", aoe, 0);
		// clock enable low: address command ignored
		@(posedge clk);
		ce <= 0;
		hc <= bdc_pkg::HOST_ADDR_DRIVE;
		@(posedge clk);
		ce <= 1;
		hc <= bdc_pkg::HOST_NOP;
		#1 chk("ce_freeze", aoe, 0);
		$display("test host done");
		// fill capture, then queue filled until refused
		for (int k = 1; k < 3; k++) begin
			x = {$random(seed), $random(seed)};
			@(posedge clk);
			mc <= k == 1 ? bdc_pkg::MEM_RD_FILL_FIRST : bdc_pkg::MEM_RD_FILL_NEXT;
			md <= x;
			@(posedge clk);
			mc <= bdc_pkg::MEM_NOP;
			md <= ~x;
			#1 chk("fill_valid", fv, 1);
			chk("fill_data", fill, x);
		end
		for (int i = 0; i < 17; i++) begin
			@(posedge clk);
			w[i] = {$random(seed), $random(seed)};
			wd <= w[i];
			wv <= 1;
		end
		@(posedge clk);
		wv <= 0;
		#1 chk("wr_full", wr, 0);
		// retire with random hold stalls
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			mc <= i[1:0] == 3 ? bdc_pkg::MEM_RETIRE_PCI_SHIFTED : i[0] ? bdc_pkg::MEM_RETIRE_PCI_WR :
				bdc_pkg::MEM_RETIRE_CPU_WR;
			@(posedge clk);
			mc <= bdc_pkg::MEM_DRIVE_HOLD;
			repeat ($random(seed) & 1) @(posedge clk);
			#1 chk("retire_data", mout, i[1:0] == 3 ? {w[i][31:0], w[i][63:32]} : w[i]);
			chk("retire_oe", moe, 1);
		end
		@(posedge clk);
		mc <= bdc_pkg::MEM_NOP;
		step(1);
		chk("mem_release", moe, 0);
		chk("wr_ready", wr, 1);
		$display("test memory done");
		// pci enable sampled on the way up, released at once
		@(posedge clk);
		own <= 1;
		pc <= 4'h4;
		pt <= $random(seed);
		pe <= 1;
		#1 chk("pci_oe_early", poe, 0);
		step(1);
		chk("pci_oe", poe, 1);
		chk("pci_ad", pout, pt);
		chk("pci_par_out", ppo, ppar(pt));
		@(posedge clk);
		pe <= 0;
		#1 chk("pci_release", poe, 0);
		$display("test pci done");
		stop_test();
	end
endmodule
